// ### hw/serial_bus_master_defs.svh
// Purpose: constants for the serial bus master
// Assumes: 250 MHz system clock, Avalon-MM register slave
// Notes:   offsets are word byte addresses
`ifndef SERIAL_BUS_MASTER_DEFS_SVH
`define SERIAL_BUS_MASTER_DEFS_SVH

`define SBM_OFS_DATA        4'h0
`define SBM_OFS_CTRL_ONE    4'h4
`define SBM_OFS_CTRL_TWO    4'h8
`define SBM_OFS_PORT_OUT    4'hc

`define SBM_C1_MODE_LO      0
`define SBM_C1_MODE_HI      1
`define SBM_C1_STOP         2
`define SBM_C1_START        3
`define SBM_C2_BUSY         0
`define SBM_C2_NOACK        1
`define SBM_C2_VERIFY       2
`define SBM_C2_DIR          3

`define SBM_PORT_RESET      3'h7
`define SBM_CLK_HZ          250000000
`define SBM_BUS_HZ          62500
// one quarter bus period per phase
`define SBM_QUARTER_CYC     (`SBM_CLK_HZ / (`SBM_BUS_HZ * 4))
`define SBM_FILTER_CYC      4

`endif

// ### hw/serial_bus_master_pkg.sv
// Purpose: types for the serial bus master
// Assumes: nothing
// Notes:   constants live in the defs header
package serial_bus_master_pkg;

    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_SHIFT = 2'b01,
        MODE_TWO   = 2'b10,
        MODE_THREE = 2'b11
    } bus_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_BIT   = 3'b010,
        ST_ACK   = 3'b011,
        ST_STOP  = 3'b100,
        ST_DONE  = 3'b101
    } seq_state_e;

endpackage : serial_bus_master_pkg

// ### hw/serial_bus_master.sv
// Purpose: single-master byte engine for two-wire, three-wire and shift modes
// Assumes: open-drain pins, resolved outside; software holds port bits high
// Notes:   one byte per busy command, bus clock four phases per bit
//
// What this block does
// R01: data register locked while byte runs
// R02: mode bits pick off, shift, two-wire, three-wire
// R03: start request sets enable, adds start
// R04: stop request sets enable, adds stop
// R05: software keeps stop clear in shift mode
// R06: direction bit picks transmit or receive
// R07: busy write starts byte, hardware clears
// R08: verify flag drops on line mismatch
// R09: verify write position drives vsync enable
// R10: missing ack flag, cleared on busy
// R11: no ack driven on last received byte
// R12: outputs anded with port outputs
// R13: software sets pins output and high
// R14: enable pin used only in three-wire
// R15: clock and data inputs deglitched
// R16: three-wire start and stop on enable
// R17: two-wire start and stop on data
// R18: three-wire data changes with clock low
// R19: ninth acknowledge bit after each byte
// R20: only this master makes start, stop
// R21: first byte carries address and direction
// R22: reset clears busy and mode bits
// R23: fixed bus rate, msb first
// R24: master waits while slave stretches clock
// R25: shift mode no ack, no conditions
`timescale 1ns/1ns
`include "serial_bus_master_defs.svh"

module serial_bus_master (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             sen_out,
    output logic             sen_oe,
    output logic             vsync_irq_enable
);

    localparam int unsigned QCYC = `SBM_QUARTER_CYC;
    localparam int unsigned FCYC = `SBM_FILTER_CYC;

    serial_bus_master_pkg::bus_mode_e  mode_reg;
    serial_bus_master_pkg::seq_state_e state_reg;
    logic [7:0]  data_reg;
    logic        start_reg;
    logic        stop_reg;
    logic        dir_reg;
    logic        busy_reg;
    logic        verify_reg;
    logic        noack_reg;
    logic [2:0]  port_reg;
    logic        scl_drv_reg;
    logic        sda_drv_reg;
    logic        sen_drv_reg;
    logic [1:0]  phase_reg;
    logic [2:0]  bit_reg;
    logic [9:0]  tick_cnt_reg;
    logic        tick;
    logic        ack_pend_reg;
    logic [1:0]  scl_sync_reg;
    logic [1:0]  sda_sync_reg;
    logic [2:0]  scl_cnt_reg;
    logic [2:0]  sda_cnt_reg;
    logic        scl_f_reg;
    logic        sda_f_reg;
    logic        wr_hit;
    logic        rd_hit;
    logic        three_wire;
    logic        proto;
    logic        stretched;
    logic        scl_hold;

    assign wr_hit     = avs_write && !avs_waitrequest;
    // read data must already stand at the edge that takes the read
    assign rd_hit     = avs_read && avs_waitrequest;
    assign three_wire = (mode_reg == serial_bus_master_pkg::MODE_THREE);
    assign proto      = mode_reg[1];
    // a tick lost to a stretch costs a quarter, never a bit
    // a slave holding clock low freezes the phase counter
    // R24: stretch waits clock
    assign stretched  = proto && scl_drv_reg && !scl_f_reg && (phase_reg == 2'd2);
    // clock stays parked where the byte left it while the engine is on;
    // floating it high between bytes would hand the slave a stray pulse
    assign scl_hold   = busy_reg || (mode_reg != serial_bus_master_pkg::MODE_OFF);

    // one-cycle wait state: an access that finds waitrequest high answers on its second edge
    // nothing is taken while waitrequest is high
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
        end
    end

    // pins are asynchronous, so two flops come before the filter
    // R15: glitch filter
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            scl_cnt_reg  <= 3'h0;
            sda_cnt_reg  <= 3'h0;
            scl_f_reg    <= 1'b1;
            sda_f_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            if (scl_sync_reg[1] == scl_f_reg) begin
                scl_cnt_reg <= 3'h0;
            end else if (scl_cnt_reg == 3'(FCYC - 1)) begin
                scl_f_reg   <= scl_sync_reg[1];
                scl_cnt_reg <= 3'h0;
            end else begin
                scl_cnt_reg <= scl_cnt_reg + 3'h1;
            end
            if (sda_sync_reg[1] == sda_f_reg) begin
                sda_cnt_reg <= 3'h0;
            end else if (sda_cnt_reg == 3'(FCYC - 1)) begin
                sda_f_reg   <= sda_sync_reg[1];
                sda_cnt_reg <= 3'h0;
            end else begin
                sda_cnt_reg <= sda_cnt_reg + 3'h1;
            end
        end
    end

    // ten bits: one quarter is a thousand system cycles
    // R23: fixed rate divider
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_reg <= 10'h0;
        end else if (!busy_reg || tick_cnt_reg == 10'(QCYC - 1)) begin
            tick_cnt_reg <= 10'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 10'h1;
        end
    end
    assign tick = busy_reg && (tick_cnt_reg == 10'(QCYC - 1)) && !stretched;

    // control register one
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // R22: reset disables
            mode_reg  <= serial_bus_master_pkg::MODE_OFF;
            start_reg <= 1'b0;
            stop_reg  <= 1'b0;
        end else if (wr_hit && avs_address == `SBM_OFS_CTRL_ONE) begin
            // R02: mode decode
            // R03: start forces enable
            // R04: stop forces enable
            mode_reg  <= serial_bus_master_pkg::bus_mode_e'({
                avs_writedata[`SBM_C1_MODE_HI] | avs_writedata[`SBM_C1_START]
                    | avs_writedata[`SBM_C1_STOP],
                avs_writedata[`SBM_C1_MODE_LO]});
            start_reg <= avs_writedata[`SBM_C1_START];
            stop_reg  <= avs_writedata[`SBM_C1_STOP];
        end
    end

    // control register two, write-side fields
    // direction is write-only and never read back
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dir_reg          <= 1'b0;
            vsync_irq_enable <= 1'b0;
        end else if (wr_hit && avs_address == `SBM_OFS_CTRL_TWO) begin
            // R06: direction write-only
            dir_reg          <= avs_writedata[`SBM_C2_DIR];
            // R09: vsync enable write
            vsync_irq_enable <= avs_writedata[`SBM_C2_VERIFY];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // port outputs reset high so the engine owns the pins
            port_reg <= `SBM_PORT_RESET;
        end else if (wr_hit && avs_address == `SBM_OFS_PORT_OUT) begin
            port_reg <= avs_writedata[2:0];
        end
    end

    // byte sequencer with busy, flags and shift register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= serial_bus_master_pkg::ST_IDLE;
            busy_reg     <= 1'b0;
            verify_reg   <= 1'b0;
            noack_reg    <= 1'b0;
            data_reg     <= 8'h00;
            scl_drv_reg  <= 1'b1;
            sda_drv_reg  <= 1'b1;
            sen_drv_reg  <= 1'b1;
            phase_reg    <= 2'd0;
            bit_reg      <= 3'd7;
            ack_pend_reg <= 1'b0;
        end else if (!busy_reg) begin
            // R01: data locked while busy
            if (wr_hit && avs_address == `SBM_OFS_DATA) begin
                data_reg <= avs_writedata[7:0];
            end
            // R07: busy starts byte
            if (wr_hit && avs_address == `SBM_OFS_CTRL_TWO &&
                avs_writedata[`SBM_C2_BUSY] && mode_reg != serial_bus_master_pkg::MODE_OFF) begin
                busy_reg   <= 1'b1;
                // R10: cleared on busy
                noack_reg  <= 1'b0;
                // R08: verify set at start
                verify_reg <= 1'b1;
                phase_reg  <= 2'd0;
                bit_reg    <= 3'd7;
                // clock falls a quarter before the first data change
                if (!(start_reg && proto)) scl_drv_reg <= 1'b0;
                // R25: shift mode skips start
                // R20: master makes start
                state_reg  <= (start_reg && proto) ? serial_bus_master_pkg::ST_START
                                                   : serial_bus_master_pkg::ST_BIT;
            end
        end else if (tick) begin
            phase_reg <= phase_reg + 2'd1;
            unique case (state_reg)
                serial_bus_master_pkg::ST_START: begin
                    // a repeated start raises both lines first
                    // release high, then drop with clock high
                    // R16: enable falls, clock high
                    // R17: data falls, clock high
                    unique case (phase_reg)
                        2'd0: begin
                            sda_drv_reg <= 1'b1;
                            sen_drv_reg <= 1'b1;
                            scl_drv_reg <= 1'b1;
                        end
                        2'd1: begin
                            if (three_wire) sen_drv_reg <= 1'b0;
                            else sda_drv_reg <= 1'b0;
                        end
                        2'd2: scl_drv_reg <= 1'b0;
                        2'd3: begin
                            // R18: enable back high, clock low
                            sen_drv_reg <= 1'b1;
                            state_reg   <= serial_bus_master_pkg::ST_BIT;
                        end
                    endcase
                end
                serial_bus_master_pkg::ST_BIT: begin
                    unique case (phase_reg)
                        2'd0: begin
                            scl_drv_reg <= 1'b0;
                            // R23: msb first
                            // R21: address byte from data
                            sda_drv_reg <= dir_reg ? data_reg[7] : 1'b1;
                        end
                        2'd1: scl_drv_reg <= 1'b1;
                        2'd2: begin
                            // R08: mismatch clears verify
                            if (dir_reg && proto && sda_f_reg != sda_drv_reg) begin
                                verify_reg <= 1'b0;
                            end
                            // transmit rotates, so the byte reads back intact
                            data_reg <= {data_reg[6:0], dir_reg ? data_reg[7] : sda_f_reg};
                        end
                        2'd3: begin
                            scl_drv_reg <= 1'b0;
                            bit_reg     <= bit_reg - 3'd1;
                            if (bit_reg == 3'd0) begin
                                // R25: shift mode no ack
                                // R19: ninth ack bit
                                state_reg <= proto ? serial_bus_master_pkg::ST_ACK
                                          : serial_bus_master_pkg::ST_DONE;
                            end
                        end
                    endcase
                end
                serial_bus_master_pkg::ST_ACK: begin
                    unique case (phase_reg)
                        // a received byte is acked only when more follow
                        // R11: no ack on last
                        2'd0: sda_drv_reg <= dir_reg || stop_reg;
                        2'd1: scl_drv_reg <= 1'b1;
                        2'd2: ack_pend_reg <= dir_reg && sda_f_reg;
                        2'd3: begin
                            scl_drv_reg <= 1'b0;
                            // R10: missing ack sets
                            noack_reg   <= ack_pend_reg;
                            state_reg   <= stop_reg ? serial_bus_master_pkg::ST_STOP
                                                    : serial_bus_master_pkg::ST_DONE;
                        end
                    endcase
                end
                serial_bus_master_pkg::ST_STOP: begin
                    // R16: enable rises, clock high
                    // R17: data rises, clock high
                    // R18: data high, enable low
                    unique case (phase_reg)
                        2'd0: begin
                            sda_drv_reg <= three_wire;
                            sen_drv_reg <= !three_wire;
                        end
                        2'd1: scl_drv_reg <= 1'b1;
                        2'd2: begin
                            sda_drv_reg <= 1'b1;
                            sen_drv_reg <= 1'b1;
                        end
                        2'd3: state_reg <= serial_bus_master_pkg::ST_DONE;
                    endcase
                end
                serial_bus_master_pkg::ST_DONE: begin
                    // busy drops a quarter after the last phase, three quarters after the last clock edge when a stop ran
                    // R07: hardware clears busy
                    if (!stop_reg) sda_drv_reg <= 1'b1;
                    busy_reg  <= 1'b0;
                    state_reg <= serial_bus_master_pkg::ST_IDLE;
                end
                default: state_reg <= serial_bus_master_pkg::ST_IDLE;
            endcase
        end
    end

    // read data; data reads zero while busy
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            unique case (avs_address)
                // R01: read blocked while busy
                `SBM_OFS_DATA:     avs_readdata <= {24'h0, busy_reg ? 8'h00 : data_reg};
                `SBM_OFS_CTRL_ONE: avs_readdata <= {28'h0, start_reg, stop_reg, mode_reg};
                `SBM_OFS_CTRL_TWO: avs_readdata <= {29'h0, verify_reg, noack_reg, busy_reg};
                `SBM_OFS_PORT_OUT: avs_readdata <= {29'h0, port_reg};
                default:           avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // open-drain pins: drive low only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            sen_out <= 1'b0;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            sen_oe  <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            sen_out <= 1'b0;
            // idle data lines are left to the pull-ups
            // R12: and with port
            scl_oe  <= !(port_reg[0] && (!scl_hold || scl_drv_reg));
            sda_oe  <= !(port_reg[1] && (!busy_reg || sda_drv_reg));
            // R14: enable only three-wire
            sen_oe  <= !(port_reg[2] && (!(busy_reg && three_wire) || sen_drv_reg));
        end
    end

endmodule : serial_bus_master

// ### tb/serial_bus_master_assertions.sv
// Purpose: port-level checks for the serial bus master
// Assumes: one clock domain, software never clears the port enable bit
// Notes:   mode is tracked from taken register writes
`timescale 1ns/1ns
module serial_bus_master_assertions (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        sen_out,
    input wire logic        sen_oe,
    input wire logic        vsync_irq_enable
);
    logic [1:0]  mode_reg;
    logic        port_sda_reg;
    logic        last_scl_reg;
    logic [15:0] gap_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg     <= 2'h0;
            port_sda_reg <= 1'b1;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == 4'h4)
                mode_reg <= {|avs_writedata[3:1], avs_writedata[0]};
            if (avs_address == 4'hc)
                port_sda_reg <= avs_writedata[1];
        end
    end
    // gap since last bus clock change, saturating
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            last_scl_reg <= 1'b0;
            gap_reg      <= 16'h0;
        end else begin
            last_scl_reg <= scl_oe;
            gap_reg      <= (scl_oe != last_scl_reg) ? 16'h0 : gap_reg + {15'h0, ~&gap_reg};
        end
    end
    reset_idle_a: assert property ($rose(arst_n) |-> !scl_oe && !sda_oe && !sen_oe)
        else $error("pins driven right after reset");
    sen_mode_a: assert property (mode_reg != 2'h3 |-> !sen_oe)
        else $error("enable pin driven outside three-wire mode");
    port_and_a: assert property ($fell(port_sda_reg) |-> ##[1:3] sda_oe)
        else $error("port data low did not pull data pin");
    vsync_wr_a: assert property (avs_write && !avs_waitrequest && avs_address == 4'h8
        |=> vsync_irq_enable == $past(avs_writedata[2]))
        else $error("vsync enable not taken from write");
    bus_rate_a: assert property (scl_oe != last_scl_reg |-> gap_reg >= 16'd999)
        else $error("bus clock phase shorter than a quarter");
    data_vs_clk_a: assert property ($changed(sda_oe) |-> !$changed(scl_oe))
        else $error("data and clock moved together");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
        |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    cover property (sda_oe && !scl_oe && $rose(sda_oe));
    cover property ($rose(scl_oe));
    cover property (!sda_oe && !scl_oe && $fell(sda_oe));
endmodule : serial_bus_master_assertions
bind serial_bus_master serial_bus_master_assertions chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .sen_out(sen_out), .sen_oe(sen_oe),
    .vsync_irq_enable(vsync_irq_enable));

// ### tb/bus_slave_model.sv
// Purpose: behavioural two-wire slave on the far side
// Assumes: pull-up on both lines, no clock stretching
// Notes:   bit count restarts on each start condition
`timescale 1ns/1ns
module bus_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic       send,
    input  wire logic [7:0] tx_byte,
    output logic            sda_pull,
    output logic [7:0]      rx_byte,
    output logic            ack_level
);
    int         cnt = 0;
    logic       fin = 1'b0;
    logic [7:0] sh  = 8'h0;
    initial begin
        sda_pull  = 1'b0;
        rx_byte   = 8'h0;
        ack_level = 1'b1;
    end
    always @(negedge sda) if (scl) cnt = 0;
    always @(posedge scl) begin
        if (cnt == 8) begin
            ack_level = sda;
            cnt = 0;
            fin = send;
        end else begin
            sh = {sh[6:0], sda};
            cnt++;
            if (cnt == 8) rx_byte = sh;
        end
    end
    // first bit must stand before the first clock rise
    always @(posedge send) sda_pull <= !tx_byte[7];
    // ack only when receiving and told to
    always @(negedge scl) begin
        if (fin || cnt == 8) sda_pull <= (cnt == 8) && ack_en && !send;
        else sda_pull <= send && !tx_byte[3'(7 - cnt)];
    end
endmodule : bus_slave_model

// ### tb/tb.sv
// Purpose: self-checking bench for the serial bus master
// Assumes: two-wire slave model, pins resolved here with pull-ups
// Notes:   two full bytes take most of the run time
`timescale 1ns/1ns
module tb;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe, sen_out, sen_oe;
    logic        vsync_irq_enable;
    logic        ack_en = 1'b0;
    logic        send = 1'b0;
    logic [7:0]  txb = 8'h0;
    logic        sen_seen = 1'b0;
    logic [31:0] q;
    wire         sda_pull, ack_level;
    wire  [7:0]  rx_byte;
    int          failures = 0, checks = 0, cycles = 0, starts = 0, stops = 0;
    wire         scl_pin = !scl_oe;
    wire         sda_pin = !sda_oe && !sda_pull;
    always #2 clk_sys = ~clk_sys;
    serial_bus_master uut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_pin),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_pin), .sda_out(sda_out),
        .sda_oe(sda_oe), .sen_out(sen_out), .sen_oe(sen_oe),
        .vsync_irq_enable(vsync_irq_enable));
    bus_slave_model slave (.scl(scl_pin), .sda(sda_pin), .ack_en(ack_en), .send(send),
        .tx_byte(txb), .sda_pull(sda_pull), .rx_byte(rx_byte), .ack_level(ack_level));
    always @(negedge sda_pin) if (scl_pin === 1'b1) starts++;
    always @(posedge sda_pin) if (scl_pin === 1'b1) stops++;
    always @(posedge sen_oe) sen_seen = 1'b1;
    task end_of_test;
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    // two bytes of 41 quarters each plus register traffic
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 95000) begin
            failures++;
            end_of_test;
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task wait_idle;
        do bus(1'b0, 4'h8, 32'h0); while (q[0] !== 1'b0);
    endtask : wait_idle
    task reset_regs;
        bus(1'b0, 4'h4, 32'h0);
        check(q, 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        check(q, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        check(q, 32'h7);
        bus(1'b0, 4'h1, 32'h0);
        check(q, 32'h0);
        check({31'h0, vsync_irq_enable}, 32'h0);
    endtask : reset_regs
    task port_and;
        bus(1'b1, 4'hc, 32'h5);
        @(posedge clk_sys);
        check({31'h0, sda_oe}, 32'h1);
        // port bits back high before any byte
        bus(1'b1, 4'hc, 32'h7);
        @(posedge clk_sys);
        check({31'h0, sda_oe}, 32'h0);
        starts = 0;
        stops = 0;
    endtask : port_and
    task off_busy;
        bus(1'b1, 4'h4, 32'h0);
        bus(1'b1, 4'h8, 32'h1);
        bus(1'b0, 4'h8, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 4'h8, 32'h4);
        check({31'h0, vsync_irq_enable}, 32'h1);
        bus(1'b1, 4'h8, 32'h0);
        check({31'h0, vsync_irq_enable}, 32'h0);
    endtask : off_busy
    task ctrl_force;
        bus(1'b1, 4'h4, 32'h9);
        bus(1'b0, 4'h4, 32'h0);
        check({30'h0, q[1:0]}, 32'h3);
        bus(1'b1, 4'h4, 32'h5);
        bus(1'b0, 4'h4, 32'h0);
        check({30'h0, q[1:0]}, 32'h3);
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b0, 4'h4, 32'h0);
        check(q, 32'h1);
        bus(1'b1, 4'h4, 32'h2);
        bus(1'b0, 4'h4, 32'h0);
        check({30'h0, q[1:0]}, 32'h2);
    endtask : ctrl_force
    task tx_byte;
        bus(1'b1, 4'h0, 32'ha6);
        bus(1'b1, 4'h4, 32'h0a);
        bus(1'b1, 4'h8, 32'h9);
        bus(1'b0, 4'h8, 32'h0);
        check({29'h0, q[2:0]}, 32'h5);
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 4'h0, 32'hff);
        wait_idle;
        check({29'h0, q[2:0]}, 32'h6);
        check({24'h0, rx_byte}, 32'ha6);
        check({31'h0, ack_level}, 32'h1);
        check(starts, 1);
        check(stops, 0);
        check({31'h0, sen_seen}, 32'h0);
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'ha6);
    endtask : tx_byte
    task rx_byte_last;
        txb  <= 8'h3c;
        send <= 1'b1;
        bus(1'b1, 4'h4, 32'h06);
        bus(1'b1, 4'h8, 32'h1);
        bus(1'b0, 4'h8, 32'h0);
        check({30'h0, q[1:0]}, 32'h1);
        wait_idle;
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h3c);
        check({31'h0, ack_level}, 32'h1);
        check(stops, 1);
        check(starts, 1);
    endtask : rx_byte_last
    initial begin
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        reset_regs;
        port_and;
        off_busy;
        ctrl_force;
        tx_byte;
        rx_byte_last;
        end_of_test;
    end
endmodule : tb
